// *** logic/aaf_cfg.svh ***
// Offsets, field positions, response codes and reset values of the accumulator datapath.
`ifndef AAF_CFG_SVH
`define AAF_CFG_SVH
`define AAF_ADDR_W      12
`define AAF_OFF_CTRL    12'h000
`define AAF_OFF_STAT    12'h004
`define AAF_CTRL_ARITH  0
`define AAF_CTRL_LOGIC  1
`define AAF_CTRL_ROT    2
`define AAF_CTRL_W      3
`define AAF_CTRL_RST    3'h7
`define AAF_ST_CARRY    8
`define AAF_ST_SIGN     9
`define AAF_ST_ZERO     10
`define AAF_ST_PARITY   11
`define AAF_RESP_OKAY   2'h0
`define AAF_RESP_SLVERR 2'h2
`define AAF_ACC_RST     8'h00
`endif

// *** logic/aaf_pkg.sv ***
// Types shared by the accumulator datapath and its users.
`default_nettype none
package aaf_pkg;
    typedef enum logic [3:0] {
        AAF_OP_NOP,
        AAF_OP_LOAD,
        AAF_OP_ADD,
        AAF_OP_ADC,
        AAF_OP_SUB,
        AAF_OP_SBB,
        AAF_OP_AND,
        AAF_OP_OR,
        AAF_OP_XOR,
        AAF_OP_RLC,
        AAF_OP_RRC,
        AAF_OP_RAL,
        AAF_OP_RAR
    } aaf_op_t;
    typedef enum logic [1:0] {
        AAF_SRC_MEM,
        AAF_SRC_PREG,
        AAF_SRC_PORT
    } aaf_src_t;
    typedef enum logic [1:0] {
        AAF_CLS_NONE,
        AAF_CLS_ARITH,
        AAF_CLS_LOGIC,
        AAF_CLS_ROT
    } aaf_cls_t;
endpackage
`default_nettype wire

// *** logic/aaf_alu.sv ***
// Accumulator datapath with condition flags and an AXI4-Lite control slave.
`timescale 1ns/1ps
`default_nettype none
`include "aaf_cfg.svh"
module aaf_alu #(
    parameter int W = 8
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    op_valid,
    input  wire aaf_pkg::aaf_op_t        op_code,
    input  wire aaf_pkg::aaf_src_t       op_src,
    input  wire logic [W-1:0]            mem_data,
    input  wire logic [W-1:0]            preg_data,
    input  wire logic [W-1:0]            port_data,
    output logic [W-1:0]                 acc_q,
    output logic                         carry_q,
    output logic                         sign_q,
    output logic                         zero_q,
    output logic                         parity_q,
    input  wire logic [`AAF_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`AAF_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    // The status word packs the accumulator below the flag fields, so wider words cannot be served.
    if (W < 2 || W > `AAF_ST_CARRY) begin : g_bad_width
        $error("aaf_alu: W must lie between 2 and the carry field position");
    end

    // Flag triple {sign, zero, even parity} of a result.
    function automatic logic [2:0] szp(input logic [W-1:0] v);
        szp = {v[W-1], ~|v, ~^v};
    endfunction

    logic [W-1:0]             acc_r;
    logic                     carry_r;
    logic                     sign_r;
    logic                     zero_r;
    logic                     parity_r;
    logic [W-1:0]             port_s1_r;
    logic [W-1:0]             port_s2_r;
    logic [`AAF_CTRL_W-1:0]   ctrl_r;

    // The port byte comes from an outside device, so it is synchronised first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_s1_r <= '0;
            port_s2_r <= '0;
        end else begin
            port_s1_r <= port_data;
            port_s2_r <= port_s1_r;
        end
    end

    wire [W-1:0] opnd = (op_src == aaf_pkg::AAF_SRC_MEM)  ? mem_data :
                        (op_src == aaf_pkg::AAF_SRC_PREG) ? preg_data : port_s2_r;
    wire         with_cy = (op_code == aaf_pkg::AAF_OP_ADC) || (op_code == aaf_pkg::AAF_OP_SBB);
    wire [W:0]   cin_ext = {{W{1'b0}}, with_cy & carry_r};
    wire [W:0]   sum = {1'b0, acc_r} + {1'b0, opnd} + cin_ext;
    wire [W:0]   dif = {1'b0, acc_r} - {1'b0, opnd} - cin_ext;

    logic [W-1:0]      res;
    logic              cy_new;
    aaf_pkg::aaf_cls_t cls;

    always_comb begin
        res    = acc_r;
        cy_new = carry_r;
        cls    = aaf_pkg::AAF_CLS_NONE;
        case (op_code)
            aaf_pkg::AAF_OP_LOAD: begin
                res = opnd;
            end
            aaf_pkg::AAF_OP_ADD, aaf_pkg::AAF_OP_ADC: begin
                res    = sum[W-1:0];
                cy_new = sum[W];
                cls    = aaf_pkg::AAF_CLS_ARITH;
            end
            aaf_pkg::AAF_OP_SUB, aaf_pkg::AAF_OP_SBB: begin
                res    = dif[W-1:0];
                cy_new = dif[W];
                cls    = aaf_pkg::AAF_CLS_ARITH;
            end
            aaf_pkg::AAF_OP_AND: begin
                res = acc_r & opnd;
                cls = aaf_pkg::AAF_CLS_LOGIC;
            end
            aaf_pkg::AAF_OP_OR: begin
                res = acc_r | opnd;
                cls = aaf_pkg::AAF_CLS_LOGIC;
            end
            aaf_pkg::AAF_OP_XOR: begin
                res = acc_r ^ opnd;
                cls = aaf_pkg::AAF_CLS_LOGIC;
            end
            aaf_pkg::AAF_OP_RLC: begin
                res    = {acc_r[W-2:0], acc_r[W-1]};
                cy_new = acc_r[W-1];
                cls    = aaf_pkg::AAF_CLS_ROT;
            end
            aaf_pkg::AAF_OP_RRC: begin
                res    = {acc_r[0], acc_r[W-1:1]};
                cy_new = acc_r[0];
                cls    = aaf_pkg::AAF_CLS_ROT;
            end
            aaf_pkg::AAF_OP_RAL: begin
                res    = {acc_r[W-2:0], carry_r};
                cy_new = acc_r[W-1];
                cls    = aaf_pkg::AAF_CLS_ROT;
            end
            aaf_pkg::AAF_OP_RAR: begin
                res    = {carry_r, acc_r[W-1:1]};
                cy_new = acc_r[0];
                cls    = aaf_pkg::AAF_CLS_ROT;
            end
            default: begin
                res = acc_r;
            end
        endcase
    end

    wire       acc_we  = op_valid && (op_code != aaf_pkg::AAF_OP_NOP);
    wire       upd_ar  = op_valid && (cls == aaf_pkg::AAF_CLS_ARITH) && ctrl_r[`AAF_CTRL_ARITH];
    wire       upd_lg  = op_valid && (cls == aaf_pkg::AAF_CLS_LOGIC) && ctrl_r[`AAF_CTRL_LOGIC];
    wire       upd_rt  = op_valid && (cls == aaf_pkg::AAF_CLS_ROT) && ctrl_r[`AAF_CTRL_ROT];
    wire       upd_szp = upd_ar || upd_lg;
    wire [2:0] szp_new = szp(res);
    // Logic results carry nothing out, so their carry is cleared.
    wire       carry_nxt = upd_ar || upd_rt ? cy_new : (upd_lg ? 1'b0 : carry_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= `AAF_ACC_RST;
        end else if (acc_we) begin
            acc_r <= res;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_r  <= 1'b0;
            sign_r   <= 1'b0;
            zero_r   <= 1'b1;
            parity_r <= 1'b1;
        end else begin
            carry_r <= carry_nxt;
            if (upd_szp) begin
                {sign_r, zero_r, parity_r} <= szp_new;
            end
        end
    end

    assign acc_q    = acc_r;
    assign carry_q  = carry_r;
    assign sign_q   = sign_r;
    assign zero_q   = zero_r;
    assign parity_q = parity_r;

    // AXI4-Lite slave: address and data are captured separately, then written together.
    logic                    aw_got_r;
    logic                    w_got_r;
    logic [`AAF_ADDR_W-1:0]  aw_addr_r;
    logic [31:0]             w_data_r;
    logic                    w_strb0_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic                    rvalid_r;
    logic [1:0]              rresp_r;
    logic [31:0]             rdata_r;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_do   = aw_got_r && w_got_r && !bvalid_r;

    // Word decode shared by both paths; the two low address bits never select a register.
    function automatic logic reg_hit(input logic [`AAF_ADDR_W-1:0] a, input logic [`AAF_ADDR_W-1:0] off);
        reg_hit = a[`AAF_ADDR_W-1:2] == off[`AAF_ADDR_W-1:2];
    endfunction

    wire wr_ctrl = reg_hit(aw_addr_r, `AAF_OFF_CTRL);
    wire wr_stat = reg_hit(aw_addr_r, `AAF_OFF_STAT);
    wire rd_ctrl = reg_hit(s_axi_araddr, `AAF_OFF_CTRL);
    wire rd_stat = reg_hit(s_axi_araddr, `AAF_OFF_STAT);

    wire [31:0] stat_word = {20'h00000, parity_r, zero_r, sign_r, carry_r, 8'(acc_r)};
    wire [31:0] ctrl_word = {{(32 - `AAF_CTRL_W){1'b0}}, ctrl_r};

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb0_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_got_r <= 1'b0;
            end
            if (w_take) begin
                w_got_r   <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_strb0_r <= s_axi_wstrb[0];
            end else if (wr_do) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // The status word is read-only; a write to it is accepted and ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= `AAF_CTRL_RST;
            bvalid_r <= 1'b0;
            bresp_r  <= `AAF_RESP_OKAY;
        end else if (wr_do) begin
            if (wr_ctrl && w_strb0_r) begin
                ctrl_r <= w_data_r[`AAF_CTRL_W-1:0];
            end
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_ctrl || wr_stat) ? `AAF_RESP_OKAY : `AAF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `AAF_RESP_OKAY;
            rdata_r  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= (rd_ctrl || rd_stat) ? `AAF_RESP_OKAY : `AAF_RESP_SLVERR;
            rdata_r  <= rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_op(aaf_pkg::aaf_op_t o);
        op_valid && op_code == o;
    endsequence

    sequence s_flag_upd;
        op_valid && ((cls == aaf_pkg::AAF_CLS_ARITH && ctrl_r[`AAF_CTRL_ARITH]) ||
                     (cls == aaf_pkg::AAF_CLS_LOGIC && ctrl_r[`AAF_CTRL_LOGIC]));
    endsequence

    a_acc_hold_idle: assert property (!op_valid || op_code == aaf_pkg::AAF_OP_NOP |=> $stable(acc_q))
        else $error("accumulator changed with no operation");
    a_load_mem_reg: assert property (s_op(aaf_pkg::AAF_OP_LOAD) and op_src != aaf_pkg::AAF_SRC_PORT
        |=> acc_r == $past(op_src == aaf_pkg::AAF_SRC_MEM ? mem_data : preg_data))
        else $error("load did not take memory or register value");
    a_load_port: assert property (s_op(aaf_pkg::AAF_OP_LOAD) and op_src == aaf_pkg::AAF_SRC_PORT
        |=> acc_r == $past(port_data, 3))
        else $error("port load did not take the synchronised byte");
    a_add_wrap: assert property (s_op(aaf_pkg::AAF_OP_ADD) |=> acc_r == W'($past(acc_r) + $past(opnd)))
        else $error("addition result wrong");
    a_sub_borrow: assert property (s_op(aaf_pkg::AAF_OP_SUB) and ctrl_r[`AAF_CTRL_ARITH]
        |=> carry_r == ($past(acc_r) < $past(opnd)) && acc_r == W'($past(acc_r) - $past(opnd)))
        else $error("subtraction or borrow wrong");
    a_xor_result: assert property (s_op(aaf_pkg::AAF_OP_XOR) |=> acc_r == ($past(acc_r) ^ $past(opnd)))
        else $error("exclusive-or result wrong");
    a_rot_wrap: assert property (s_op(aaf_pkg::AAF_OP_RRC) ##1 s_op(aaf_pkg::AAF_OP_RLC)
        |=> acc_r == $past(acc_r, 2))
        else $error("right then left rotate did not restore value");
    a_rot_right: assert property (s_op(aaf_pkg::AAF_OP_RRC) |=> acc_r[W-1] == $past(acc_r[0]))
        else $error("right rotate lost the bottom bit");
    a_flag_match: assert property (s_flag_upd |=> sign_q == acc_r[W-1] && zero_q == (acc_r == '0))
        else $error("sign or zero flag disagrees with result");
    a_parity_even: assert property (s_flag_upd |=> parity_q == ~^acc_r)
        else $error("parity flag wrong");
    a_zero_hold: assert property (s_op(aaf_pkg::AAF_OP_LOAD) |=> $stable({carry_r, sign_r, zero_r, parity_r}))
        else $error("load disturbed the flags");

endmodule
`default_nettype wire

// *** testbench/aaf_seq_model.sv ***
// Behavioural instruction sequencer and register file feeding the accumulator datapath.
`timescale 1ns/1ps
`default_nettype none
module aaf_seq_model (
    input  wire logic              aclk,
    output var logic               op_valid,
    output var aaf_pkg::aaf_op_t   op_code,
    output var aaf_pkg::aaf_src_t  op_src,
    output var logic [7:0]         mem_data,
    output var logic [7:0]         preg_data,
    output var logic [7:0]         port_data
);
    initial begin
        op_valid = 1'b0;
        op_code = aaf_pkg::AAF_OP_NOP;
        op_src = aaf_pkg::AAF_SRC_MEM;
        mem_data = 8'h00;
        preg_data = 8'h00;
        port_data = 8'h00;
    end

    // One operation per call; calls back to back keep the strobe high every cycle.
    task automatic send(input logic [3:0] code, input aaf_pkg::aaf_src_t src, input logic [7:0] m,
                        input logic [7:0] p);
        @(posedge aclk);
        op_valid <= 1'b1;
        op_code <= aaf_pkg::aaf_op_t'(code);
        op_src <= src;
        mem_data <= m;
        preg_data <= p;
    endtask

    // Released operands are inverted so a stale value is never mistaken for a live one.
    task automatic idle;
        @(posedge aclk);
        op_valid <= 1'b0;
        op_code <= aaf_pkg::AAF_OP_NOP;
        mem_data <= ~mem_data;
        preg_data <= ~preg_data;
    endtask

    // The port byte is asynchronous, so it settles for three edges before any use.
    task automatic set_port(input logic [7:0] v);
        @(posedge aclk);
        port_data <= v;
        repeat (3) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// *** testbench/accumulator_alu_with_flags_tb_top.sv ***
// Self-checking testbench for the accumulator datapath and its control registers.
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_with_flags_tb_top;
    logic              aclk;
    logic              aresetn;
    logic              op_valid;
    aaf_pkg::aaf_op_t  op_code;
    aaf_pkg::aaf_src_t op_src;
    logic [7:0]        mem_data;
    logic [7:0]        preg_data;
    logic [7:0]        port_data;
    logic [7:0]        acc_q;
    logic              carry_q;
    logic              sign_q;
    logic              zero_q;
    logic              parity_q;
    logic [11:0]       awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [11:0]       araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    int                fails;
    int                tests_run;
    integer            seed;
    logic [11:0]       st;
    logic [2:0]        ctrl;
    logic [31:0]       r;
    wire  [11:0]       obs = {parity_q, zero_q, sign_q, carry_q, acc_q};
    // Opening run, each entry {operand, 2'b00, source, code}: carry out, carry-in add, borrow,
    // borrow-in subtract, end-bit wrap both ways, rotates through carry, a zero result, NOP, undefined code.
    logic [15:0]       corner [0:12] = '{16'hc001, 16'h5002, 16'h0f03, 16'h2104, 16'h0005, 16'h8101, 16'h000a,
                                         16'h0009, 16'h000b, 16'h000c, 16'h8108, 16'h0000, 16'h000d};

    always #4 aclk = ~aclk;

    aaf_seq_model u_seq (.aclk(aclk), .op_valid(op_valid), .op_code(op_code), .op_src(op_src),
        .mem_data(mem_data), .preg_data(preg_data), .port_data(port_data));

    aaf_alu #(.W(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .op_valid(op_valid), .op_code(op_code),
        .op_src(op_src), .mem_data(mem_data), .preg_data(preg_data), .port_data(port_data),
        .acc_q(acc_q), .carry_q(carry_q), .sign_q(sign_q), .zero_q(zero_q), .parity_q(parity_q),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic conclude;
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected {parity, zero, sign, carry, acc} after one operation; flag classes follow ctrl.
    function automatic logic [11:0] ref_op(input logic [3:0] op, input logic [7:0] d,
                                           input logic [11:0] s, input logic [2:0] c);
        logic [8:0] t;
        logic [7:0] a;
        logic       cy;
        logic       f;
        a = s[7:0];
        cy = s[8];
        f = 1'b0;
        t = {1'b0, d} + {8'h00, cy & op[0]};
        case (aaf_pkg::aaf_op_t'(op))
            aaf_pkg::AAF_OP_LOAD: a = d;
            aaf_pkg::AAF_OP_ADD, aaf_pkg::AAF_OP_ADC: begin
                t = {1'b0, a} + t;
                a = t[7:0];
                cy = c[0] ? t[8] : cy;
                f = c[0];
            end
            aaf_pkg::AAF_OP_SUB, aaf_pkg::AAF_OP_SBB: begin
                cy = c[0] ? ({1'b0, a} < t) : cy;
                a = a - t[7:0];
                f = c[0];
            end
            aaf_pkg::AAF_OP_AND, aaf_pkg::AAF_OP_OR, aaf_pkg::AAF_OP_XOR: begin
                a = (op == 4'd6) ? (a & d) : (op == 4'd7) ? (a | d) : (a ^ d);
                cy = c[1] ? 1'b0 : cy;
                f = c[1];
            end
            aaf_pkg::AAF_OP_RLC, aaf_pkg::AAF_OP_RRC, aaf_pkg::AAF_OP_RAL, aaf_pkg::AAF_OP_RAR: begin
                t = (op == 4'd9) ? {a, a[7]} : (op == 4'd10) ? {a[0], a[0], a[7:1]} :
                    (op == 4'd11) ? {a, cy} : {a[0], cy, a[7:1]};
                a = t[7:0];
                cy = c[2] ? t[8] : cy;
            end
            default: a = s[7:0];
        endcase
        return f ? {~^a, a == 8'h00, a[7], cy, a} : {s[11:9], cy, a};
    endfunction

    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] sb, input logic [1:0] er);
        logic ah;
        logic wh;
        logic v;
        logic [1:0] rs;
        int n;
        v = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= sb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!v) begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            v = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                conclude;
            end
        end
        bready <= 1'b0;
        check({30'h0, rs}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] ed, input logic [1:0] er);
        logic ah;
        logic v;
        logic [31:0] d;
        logic [1:0] rs;
        int n;
        v = 1'b0;
        n = 0;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!v) begin
            @(negedge aclk);
            ah = arvalid & arready;
            v = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                conclude;
            end
        end
        rready <= 1'b0;
        check(d, ed);
        check({30'h0, rs}, {30'h0, er});
    endtask

    // The check sees the previous operation's result while this one is on the port.
    task automatic do_op(input logic [3:0] code, input logic [1:0] sr, input logic [7:0] m, input logic [7:0] p);
        u_seq.send(code, aaf_pkg::aaf_src_t'(sr), m, p);
        @(negedge aclk);
        check({20'h0, obs}, {20'h0, st});
        st = ref_op(code, (sr == 2'd0) ? m : (sr == 2'd1) ? p : port_data, st, ctrl);
    endtask

    initial begin
        seed = 32'h4559;
        aclk = 1'b0;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
        fails = 0;
        tests_run = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        st = 12'hc00;
        ctrl = 3'h7;
        rd(12'h000, 32'h7, 2'h0);
        rd(12'h008, 32'h0, 2'h2);
        wr(12'h00c, 32'h0, 4'hf, 2'h2);
        wr(12'h000, 32'h0, 4'h0, 2'h0);
        wr(12'h004, 32'hfff, 4'hf, 2'h0);
        rd(12'h000, 32'h7, 2'h0);
        rd(12'h004, {20'h0, st}, 2'h0);
        for (int b = 0; b < 12; b++) begin
            r = $random(seed);
            u_seq.set_port(r[7:0]);
            ctrl = (b == 0) ? 3'h7 : r[10:8];
            wr(12'h000, {29'h0, ctrl}, 4'h1, 2'h0);
            rd(12'h000, {29'h0, ctrl}, 2'h0);
            for (int i = 0; i < 20; i++) begin
                r = $random(seed);
                if (b == 0 && i < 13) r[15:0] = corner[i];
                do_op(r[3:0], (r[5:4] == 2'd3) ? 2'd2 : r[5:4], r[15:8], r[23:16]);
            end
            u_seq.idle;
            @(negedge aclk);
            check({20'h0, obs}, {20'h0, st});
            rd(12'h004, {20'h0, st}, 2'h0);
        end
        // A reset after the last batch must bring back the power-up state and control value.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check({20'h0, obs}, 32'h00000c00);
        rd(12'h000, 32'h7, 2'h0);
        rd(12'h004, 32'h00000c00, 2'h0);
        conclude;
    end
endmodule
`default_nettype wire
